/* inc/timer2_pkg.sv */
// What this block does
// R1: Counter clock is I/O clock unless async selected.
// R2: Prescaler gives /1, /8, /32, /64, /128, /256, /1024, stop.
// R3: Prescaler-reset bit restarts prescaler phase.
// R4: Async writes land after two oscillator edges.
// R5: Each async register owns its holding latch.
// R6: Software waits for busy flag before rewriting.
// R7: Pending counter or compare write blocks matches.
// R8: Wake logic rearms one oscillator cycle later.
// R9: Async sleep wake starts on next timer edge.
// R10: Counter reads via oscillator-edge snapshot register.
// R11: Async flags arrive three cycles after event.
// R12: Compare output changes on timer tick, unsynchronised.
// R13: Software follows the clock-source switch sequence.
// R14: Source switch need not preserve timer registers.
// R15: Async select detaches oscillator pins from port.
// R16: Software sets external-clock bit for clock input.
// R17: Oscillator stops in deep sleep; registers lost.
// R18: Force strobe makes immediate match in non-PWM.
// R19: Force sets no flag, no clear, reads zero.
// R20: Software writes force zero in PWM modes.
// R21: Waveform field picks normal, phase, CTC, fast.
// R22: Software reads counter after busy handshake.
// R23: Busy flag sets on async write, clears on load.
// R24: Clock-select field encodes stop, /1, prescaled taps.
package timer2_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] CTRL_OFFSET       = 8'hB0;
  localparam logic [7:0] COUNT_OFFSET      = 8'hB4;
  localparam logic [7:0] COMPARE_OFFSET    = 8'hB8;
  localparam logic [7:0] ASYNC_STAT_OFFSET = 8'hBC;
  localparam logic [7:0] GEN_CTRL_OFFSET   = 8'hC0;
  localparam logic [7:0] IRQ_EN_OFFSET     = 8'hC4;
  localparam logic [7:0] IRQ_FLAG_OFFSET   = 8'hC8;

  localparam int unsigned CTRL_FORCE_BIT = 7;
  localparam int unsigned CTRL_WGM0_BIT  = 6;
  localparam int unsigned CTRL_COM_LSB   = 4;
  localparam int unsigned CTRL_WGM1_BIT  = 3;
  localparam int unsigned CTRL_CS_LSB    = 0;

  localparam int unsigned STAT_EXT_BIT   = 4;
  localparam int unsigned STAT_ASYNC_BIT = 3;
  localparam int unsigned GEN_PSR_BIT    = 0;
  localparam int unsigned IRQ_CMP_BIT    = 1;
  localparam int unsigned IRQ_OVF_BIT    = 0;

  // Slot index equals the busy bit position in the async status register.
  localparam int unsigned SLOT_CTRL    = 0;
  localparam int unsigned SLOT_COMPARE = 1;
  localparam int unsigned SLOT_COUNT   = 2;
  localparam int unsigned SLOTS        = 3;

  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX     = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM  = 8'h00;

  localparam logic [1:0] LATCH_LAST_EDGE  = 2'h1;
  localparam int unsigned FLAG_SYNC_CYCLES = 3;

  localparam int unsigned PRESC_W = 10;
  localparam logic [9:0] PRESC_MASK_8    = 10'h007;
  localparam logic [9:0] PRESC_MASK_32   = 10'h01F;
  localparam logic [9:0] PRESC_MASK_64   = 10'h03F;
  localparam logic [9:0] PRESC_MASK_128  = 10'h07F;
  localparam logic [9:0] PRESC_MASK_256  = 10'h0FF;
  localparam logic [9:0] PRESC_MASK_1024 = 10'h3FF;

  typedef enum logic [1:0] {
    WAVE_NORMAL    = 2'b00,
    WAVE_PHASE_PWM = 2'b01,
    WAVE_CTC       = 2'b10,
    WAVE_FAST_PWM  = 2'b11
  } wave_mode_t;

  typedef enum logic [2:0] {
    CS_STOP = 3'b000,
    CS_DIV1 = 3'b001,
    CS_DIV8 = 3'b010,
    CS_DIV32 = 3'b011,
    CS_DIV64 = 3'b100,
    CS_DIV128 = 3'b101,
    CS_DIV256 = 3'b110,
    CS_DIV1024 = 3'b111
  } clock_sel_t;

endpackage

/* rtl/async_timer2.sv */
`timescale 1ns/1ps
module async_timer2 (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      arst_n,
  // Register port
  input  wire logic [timer2_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [timer2_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [timer2_pkg::DATA_W-1:0]  reg_rdata,
  // Timer oscillator
  input  wire logic                      osc_pin_in,
  input  wire logic                      osc_halt,
  output logic                           osc_xtal_enable,
  output logic                           osc_pins_detached,
  // Sleep and wake
  input  wire logic                      sleep_save,
  output logic                           wake_req,
  // Compare output
  output logic                           compare_output_pin,
  output logic                           compare_output_en,
  // Interrupt requests and vector acknowledges
  output logic                           irq_compare,
  output logic                           irq_overflow,
  input  wire logic                      irq_compare_ack,
  input  wire logic                      irq_overflow_ack
);
  import timer2_pkg::*;

  // Oscillator pin synchroniser; stages two and three feed the edge detector.
  logic osc_s1_r;
  logic osc_s2_r;
  logic osc_s3_r;
  logic osc_rise;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else begin
      osc_s1_r <= osc_pin_in;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  logic async_r;
  logic ext_clk_r;
  assign osc_rise = osc_s2_r && !osc_s3_r && !osc_halt;  // see R17

  // Address decode.
  logic wr_ctrl;
  logic wr_count;
  logic wr_compare;
  logic wr_stat;
  logic wr_gen;
  logic wr_en;
  logic wr_flag;
  assign wr_ctrl    = reg_wr && (reg_addr == CTRL_OFFSET);
  assign wr_count   = reg_wr && (reg_addr == COUNT_OFFSET);
  assign wr_compare = reg_wr && (reg_addr == COMPARE_OFFSET);
  assign wr_stat    = reg_wr && (reg_addr == ASYNC_STAT_OFFSET);
  assign wr_gen     = reg_wr && (reg_addr == GEN_CTRL_OFFSET);
  assign wr_en      = reg_wr && (reg_addr == IRQ_EN_OFFSET);
  assign wr_flag    = reg_wr && (reg_addr == IRQ_FLAG_OFFSET);

  // Per-register holding latches for asynchronous writes.
  logic [SLOTS-1:0] slot_wr;
  logic [SLOTS-1:0] busy;
  logic [SLOTS-1:0] commit;
  logic [7:0]       temp [SLOTS];
  logic             src_changed;
  assign slot_wr[SLOT_CTRL]    = wr_ctrl;
  assign slot_wr[SLOT_COMPARE] = wr_compare;
  assign slot_wr[SLOT_COUNT]   = wr_count;

  for (genvar k = 0; k < SLOTS; k++) begin : g_slot  // see R5
    logic [7:0] temp_r;
    logic [7:0] temp_nxt;
    logic       busy_r;
    logic       busy_nxt;
    logic [1:0] edge_r;
    logic [1:0] edge_nxt;

    always_comb begin
      temp_nxt  = temp_r;
      busy_nxt  = busy_r;
      edge_nxt  = edge_r;
      commit[k] = busy_r && osc_rise && (edge_r == LATCH_LAST_EDGE);  // see R4
      if (commit[k]) begin
        busy_nxt = 1'b0;  // see R23
      end else if (busy_r && osc_rise) begin
        edge_nxt = edge_r + 2'h1;
      end
      // A new write wins over a commit in the same cycle.
      if (slot_wr[k] && async_r) begin
        temp_nxt = reg_wdata;
        busy_nxt = 1'b1;  // see R23
        edge_nxt = 2'h0;
      end
      // Pending transfers are abandoned when the source changes.
      if (src_changed) begin
        busy_nxt = 1'b0;  // see R14
      end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        temp_r <= 8'h00;
        busy_r <= 1'b0;
        edge_r <= 2'h0;
      end else begin
        temp_r <= temp_nxt;
        busy_r <= busy_nxt;
        edge_r <= edge_nxt;
      end
    end

    assign busy[k] = busy_r;
    assign temp[k] = temp_r;
  end

  // Destination loads: direct in synchronous mode, from latches otherwise.
  logic       load_ctrl;
  logic       load_count;
  logic       load_compare;
  logic [7:0] val_ctrl;
  logic [7:0] val_count;
  logic [7:0] val_compare;
  assign load_ctrl    = async_r ? commit[SLOT_CTRL] : wr_ctrl;
  assign load_count   = async_r ? commit[SLOT_COUNT] : wr_count;
  assign load_compare = async_r ? commit[SLOT_COMPARE] : wr_compare;
  assign val_ctrl     = async_r ? temp[SLOT_CTRL] : reg_wdata;
  assign val_count    = async_r ? temp[SLOT_COUNT] : reg_wdata;
  assign val_compare  = async_r ? temp[SLOT_COMPARE] : reg_wdata;

  // Timer clock source and prescaler.
  logic src_tick;
  logic timer_tick;
  logic [7:0] ctrl_r;
  assign src_tick = async_r ? osc_rise : 1'b1;  // see R1

  timer_prescaler #(
    .WIDTH (PRESC_W)
  ) u_presc (
    .ref_clk      (ref_clk),
    .arst_n       (arst_n),
    .src_tick     (src_tick),
    .presc_clear  (wr_gen && reg_wdata[GEN_PSR_BIT]),  // see R3
    .clock_select (ctrl_r[CTRL_CS_LSB +: 3]),
    .count_tick   (timer_tick)
  );

  // Core timer state.
  logic [7:0] ctrl_nxt;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [7:0] compare_r;
  logic [7:0] compare_nxt;
  logic [7:0] cmp_act_r;
  logic [7:0] cmp_act_nxt;
  logic       down_r;
  logic       down_nxt;
  logic       oc_r;
  logic       oc_nxt;
  logic       block_r;
  logic       block_nxt;
  logic       async_nxt;
  logic       ext_clk_nxt;
  logic       halt_d_r;
  logic [7:0] shadow_r;
  logic [7:0] shadow_nxt;
  logic [1:0] flags_r;
  logic [1:0] flags_nxt;
  logic [1:0] irq_en_r;
  logic [1:0] irq_en_nxt;
  logic [1:0] pipe_r [FLAG_SYNC_CYCLES];
  logic [1:0] event_now;
  logic [1:0] flag_set;
  logic       wake_pend_r;
  logic       wake_pend_nxt;
  logic       wake_lock_r;
  logic       wake_lock_nxt;
  logic       wake_r;
  logic       wake_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  wave_mode_t mode;
  logic [1:0] com;
  logic       match;
  logic       ovf;
  logic       force_cmp;
  logic       lost;

  assign mode        = wave_mode_t'({ctrl_r[CTRL_WGM1_BIT], ctrl_r[CTRL_WGM0_BIT]});  // see R21
  assign com         = ctrl_r[CTRL_COM_LSB +: 2];
  assign src_changed = wr_stat && (reg_wdata[STAT_ASYNC_BIT] != async_r);
  assign lost        = halt_d_r && !osc_halt && async_r;  // see R17

  always_comb begin
    ctrl_nxt      = ctrl_r;
    count_nxt     = count_r;
    compare_nxt   = compare_r;
    cmp_act_nxt   = cmp_act_r;
    down_nxt      = down_r;
    oc_nxt        = oc_r;
    block_nxt     = block_r;
    async_nxt     = async_r;
    ext_clk_nxt   = ext_clk_r;
    shadow_nxt    = shadow_r;
    irq_en_nxt    = irq_en_r;
    wake_pend_nxt = wake_pend_r;
    wake_lock_nxt = wake_lock_r;
    wake_nxt      = 1'b0;
    rdata_nxt     = 8'h00;
    ovf           = 1'b0;
    // Matches are held off while a counter or compare write is in flight.
    match = timer_tick && (count_r == cmp_act_r) && !block_r
            && !busy[SLOT_COUNT] && !busy[SLOT_COMPARE];  // see R7
    force_cmp = load_ctrl && val_ctrl[CTRL_FORCE_BIT]
                && !val_ctrl[CTRL_WGM0_BIT];  // see R18

    if (timer_tick) begin
      block_nxt = 1'b0;
      unique case (mode)
        WAVE_NORMAL, WAVE_FAST_PWM: begin
          count_nxt = count_r + 8'h01;
          ovf       = (count_r == COUNT_MAX);
          if (mode == WAVE_FAST_PWM && count_r == COUNT_MAX) begin
            cmp_act_nxt = compare_r;
            if (com[1]) oc_nxt = !com[0];
          end
        end
        WAVE_CTC: begin
          count_nxt = (count_r == cmp_act_r) ? COUNT_BOTTOM : count_r + 8'h01;
          ovf       = (count_r == COUNT_MAX);
        end
        WAVE_PHASE_PWM: begin
          if (!down_r && count_r == COUNT_MAX) begin
            down_nxt    = 1'b1;
            count_nxt   = count_r - 8'h01;
            cmp_act_nxt = compare_r;
          end else if (down_r && count_r == COUNT_BOTTOM) begin
            down_nxt  = 1'b0;
            count_nxt = count_r + 8'h01;
            ovf       = 1'b1;
          end else begin
            count_nxt = down_r ? count_r - 8'h01 : count_r + 8'h01;
          end
        end
      endcase
    end
    if (mode == WAVE_NORMAL || mode == WAVE_CTC) begin
      cmp_act_nxt = compare_r;
    end

    // Output pin moves on the timer tick itself, not on a synchronised copy.
    if (match || force_cmp) begin  // see R12
      unique case (mode)
        WAVE_NORMAL, WAVE_CTC: begin
          if (com == 2'b01) oc_nxt = !oc_r;
          else if (com != 2'b00) oc_nxt = com[0];
        end
        WAVE_FAST_PWM: begin
          if (com[1]) oc_nxt = com[0];
        end
        WAVE_PHASE_PWM: begin
          if (com[1]) oc_nxt = com[0] ^ down_r;
        end
      endcase
    end

    if (load_ctrl) begin
      ctrl_nxt = {1'b0, val_ctrl[6:0]};  // see R19
    end
    if (load_count) begin
      count_nxt = val_count;
      block_nxt = 1'b1;
    end
    if (load_compare) begin
      compare_nxt = val_compare;
    end
    if (lost) begin
      ctrl_nxt    = CTRL_RESET;
      count_nxt   = COUNT_RESET;
      compare_nxt = COMPARE_RESET;
    end

    if (wr_stat) begin
      async_nxt   = reg_wdata[STAT_ASYNC_BIT];
      ext_clk_nxt = reg_wdata[STAT_EXT_BIT];
    end
    if (wr_en) begin
      irq_en_nxt = reg_wdata[1:0];
    end

    // Snapshot refreshes only on oscillator edges while asynchronous.
    if (!async_r || osc_rise) begin
      shadow_nxt = count_r;  // see R10
    end

    // Wake: condition seen in sleep, wake issued on the next timer edge.
    if (sleep_save && async_r && !wake_lock_r && |({match, ovf} & irq_en_r)) begin
      wake_pend_nxt = 1'b1;
    end
    if (wake_pend_r && osc_rise) begin
      wake_nxt      = 1'b1;  // see R9
      wake_pend_nxt = 1'b0;
      wake_lock_nxt = 1'b1;
    end else if (wake_lock_r && osc_rise) begin
      wake_lock_nxt = 1'b0;  // see R8
    end

    if (reg_rd) begin
      unique case (reg_addr)
        CTRL_OFFSET:       rdata_nxt = ctrl_r;
        COUNT_OFFSET:      rdata_nxt = async_r ? shadow_r : count_r;  // see R10
        COMPARE_OFFSET:    rdata_nxt = compare_r;
        ASYNC_STAT_OFFSET: rdata_nxt = {3'b000, ext_clk_r, async_r, busy};
        IRQ_EN_OFFSET:     rdata_nxt = {6'b00_0000, irq_en_r};
        IRQ_FLAG_OFFSET:   rdata_nxt = {6'b00_0000, flags_r};
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  // Flag events: the forced compare never reaches here.
  assign event_now[IRQ_CMP_BIT] = match;  // see R19
  assign event_now[IRQ_OVF_BIT] = ovf;
  assign flag_set  = async_r ? pipe_r[FLAG_SYNC_CYCLES-1] : event_now;  // see R11
  assign flags_nxt = (flags_r & ~({2{wr_flag}} & reg_wdata[1:0])
                      & ~{irq_compare_ack, irq_overflow_ack}) | flag_set;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < FLAG_SYNC_CYCLES; i++) pipe_r[i] <= 2'b00;
    end else begin
      pipe_r[0] <= event_now;
      for (int i = 1; i < FLAG_SYNC_CYCLES; i++) pipe_r[i] <= pipe_r[i-1];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r      <= CTRL_RESET;
      count_r     <= COUNT_RESET;
      compare_r   <= COMPARE_RESET;
      cmp_act_r   <= COMPARE_RESET;
      down_r      <= 1'b0;
      oc_r        <= 1'b0;
      block_r     <= 1'b0;
      async_r     <= 1'b0;
      ext_clk_r   <= 1'b0;
      halt_d_r    <= 1'b0;
      shadow_r    <= COUNT_RESET;
      flags_r     <= 2'b00;
      irq_en_r    <= 2'b00;
      wake_pend_r <= 1'b0;
      wake_lock_r <= 1'b0;
      wake_r      <= 1'b0;
      rdata_r     <= 8'h00;
    end else begin
      ctrl_r      <= ctrl_nxt;
      count_r     <= count_nxt;
      compare_r   <= compare_nxt;
      cmp_act_r   <= cmp_act_nxt;
      down_r      <= down_nxt;
      oc_r        <= oc_nxt;
      block_r     <= block_nxt;
      async_r     <= async_nxt;
      ext_clk_r   <= ext_clk_nxt;
      halt_d_r    <= osc_halt;
      shadow_r    <= shadow_nxt;
      flags_r     <= flags_nxt;
      irq_en_r    <= irq_en_nxt;
      wake_pend_r <= wake_pend_nxt;
      wake_lock_r <= wake_lock_nxt;
      wake_r      <= wake_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  assign reg_rdata          = rdata_r;
  assign osc_pins_detached  = async_r;  // see R15
  assign osc_xtal_enable    = async_r && !ext_clk_r && !osc_halt;
  assign wake_req           = wake_r;
  assign compare_output_pin = oc_r;
  assign compare_output_en  = (com != 2'b00);
  assign irq_compare        = flags_r[IRQ_CMP_BIT] && irq_en_r[IRQ_CMP_BIT];
  assign irq_overflow       = flags_r[IRQ_OVF_BIT] && irq_en_r[IRQ_OVF_BIT];

endmodule

/* rtl/timer_prescaler.sv */
`timescale 1ns/1ps
module timer_prescaler #(
  parameter int unsigned WIDTH = timer2_pkg::PRESC_W
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Source and control
  input  wire logic       src_tick,
  input  wire logic       presc_clear,
  input  wire logic [2:0] clock_select,
  // Prescaled timer tick
  output logic            count_tick
);
  import timer2_pkg::*;

  if (WIDTH != PRESC_W) begin : g_width_check
    $error("timer_prescaler: WIDTH must equal PRESC_W");
  end

  logic [WIDTH-1:0] presc_r;
  logic [WIDTH-1:0] presc_nxt;
  logic [WIDTH-1:0] tap_mask;

  always_comb begin
    tap_mask   = '0;
    count_tick = 1'b0;
    unique case (clock_sel_t'(clock_select))  // see R24
      CS_STOP:    tap_mask = '0;
      CS_DIV1:    tap_mask = '0;
      CS_DIV8:    tap_mask = PRESC_MASK_8;
      CS_DIV32:   tap_mask = PRESC_MASK_32;
      CS_DIV64:   tap_mask = PRESC_MASK_64;
      CS_DIV128:  tap_mask = PRESC_MASK_128;
      CS_DIV256:  tap_mask = PRESC_MASK_256;
      CS_DIV1024: tap_mask = PRESC_MASK_1024;
    endcase
    // A tap fires when all of its low prescaler bits are ones.
    if (clock_select != CS_STOP) begin
      count_tick = src_tick && ((presc_r & tap_mask) == tap_mask);  // see R2
    end
    presc_nxt = presc_r;
    if (presc_clear) begin
      presc_nxt = '0;  // see R3
    end else if (src_tick) begin
      presc_nxt = presc_r + WIDTH'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_nxt;
    end
  end

endmodule

/* sim/async_timer2_monitor.sv */
`timescale 1ns/1ps
module async_timer2_monitor
  import timer2_pkg::*;
(
  // Clock and reset
  input wire logic                          ref_clk,
  input wire logic                          arst_n,
  // Register port
  input wire logic [timer2_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [timer2_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [timer2_pkg::DATA_W-1:0] reg_rdata,
  // Oscillator, wake and outputs
  input wire logic                          osc_halt,
  input wire logic                          osc_xtal_enable,
  input wire logic                          osc_pins_detached,
  input wire logic                          wake_req,
  input wire logic                          compare_output_en,
  input wire logic                          irq_overflow
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside reply cycle");
  property p_force_zero;
    reg_rd && reg_addr == CTRL_OFFSET |=> reg_rdata[CTRL_FORCE_BIT] == 1'b0;
  endproperty
  a_force_zero: assert property (p_force_zero)
    else $error("force bit read back as one");
  property p_strobe_regs;
    reg_rd && (reg_addr == GEN_CTRL_OFFSET || reg_addr == 8'h01) |=> reg_rdata == 8'h00;
  endproperty
  a_strobe_regs: assert property (p_strobe_regs)
    else $error("strobe or unmapped read not zero");
  property p_detach;
    reg_wr && reg_addr == ASYNC_STAT_OFFSET |=>
      osc_pins_detached == $past(reg_wdata[STAT_ASYNC_BIT]);
  endproperty
  a_detach: assert property (p_detach)
    else $error("pin detach does not follow async select");
  property p_xtal_sync;
    !osc_pins_detached && !$past(osc_pins_detached) |-> !osc_xtal_enable;
  endproperty
  a_xtal_sync: assert property (p_xtal_sync)
    else $error("oscillator enabled in sync mode");
  property p_halt;
    osc_halt [*2] |-> !osc_xtal_enable;
  endproperty
  a_halt: assert property (p_halt)
    else $error("oscillator enabled while halted");
  property p_com_en;
    reg_wr && reg_addr == CTRL_OFFSET && !osc_pins_detached |=>
      compare_output_en == ($past(reg_wdata[5:4]) != 2'b00);
  endproperty
  a_com_en: assert property (p_com_en)
    else $error("compare output enable wrong after control write");
  property p_wake_pulse;
    wake_req |=> !wake_req;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake request longer than one cycle");
  property p_wake_async;
    wake_req |-> osc_pins_detached;
  endproperty
  a_wake_async: assert property (p_wake_async)
    else $error("wake request outside async mode");
  property p_irq_mask;
    reg_wr && reg_addr == IRQ_EN_OFFSET && !reg_wdata[IRQ_OVF_BIT] |=> !irq_overflow;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("overflow request while masked");
endmodule
bind async_timer2 async_timer2_monitor i_mon (
  .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_halt(osc_halt),
  .osc_xtal_enable(osc_xtal_enable), .osc_pins_detached(osc_pins_detached),
  .wake_req(wake_req), .compare_output_en(compare_output_en), .irq_overflow(irq_overflow)
);

/* sim/async_timer2_tb.sv */
`timescale 1ns/1ps
module async_timer2_tb;
  import timer2_pkg::*;
  logic       ref_clk, arst_n, reg_wr, reg_rd, osc_pin_in, osc_halt, sleep_save;
  logic       xtal_en, detached, wake_req, cmp_pin, cmp_en, irq_cmp, irq_ovf, ovf_ack, cmp_ack;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, c0;
  int         num_errors, tests_run, cyc, n;
  int         div[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [7:0] offs[6] = '{CTRL_OFFSET, COUNT_OFFSET, COMPARE_OFFSET, ASYNC_STAT_OFFSET,
                          IRQ_EN_OFFSET, IRQ_FLAG_OFFSET};
  async_timer2 i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .osc_pin_in(osc_pin_in), .osc_halt(osc_halt), .osc_xtal_enable(xtal_en),
    .osc_pins_detached(detached), .sleep_save(sleep_save), .wake_req(wake_req),
    .compare_output_pin(cmp_pin), .compare_output_en(cmp_en), .irq_compare(irq_cmp),
    .irq_overflow(irq_ovf), .irq_compare_ack(cmp_ack), .irq_overflow_ack(ovf_ack));
  osc_model #(.HALF(10)) i_osc (.ref_clk(ref_clk), .run(xtal_en), .osc(osc_pin_in));
  task automatic end_sim();
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Each access waits an edge first, so a strobe is never lowered and raised in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_idle();
    logic [7:0] s;
    int k;
    k = 0;
    do begin
      rd(ASYNC_STAT_OFFSET, s);
      k++;
    end while (s[2:0] !== 3'b000 && k < 60);
    chk({5'b0, s[2:0]}, 8'h00);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge ref_clk);
      cyc++;
      if (cyc == 40000) begin
        num_errors++;
        end_sim();
      end
    end
  end
  initial begin
    arst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    osc_halt = 1'b0; sleep_save = 1'b0; ovf_ack = 1'b0; num_errors = 0; tests_run = 0;
    cmp_ack = 1'b0;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    foreach (offs[i]) begin
      rd(offs[i], v);
      chk(v, 8'h00);
    end
    wr(CTRL_OFFSET, 8'h7F);
    rd(CTRL_OFFSET, v);
    chk(v, 8'h7F);
    wr(8'h01, 8'hFF);
    rd(8'h01, v);
    chk(v, 8'h00);
    for (int cs = 1; cs < 8; cs++) begin
      wr(CTRL_OFFSET, 8'h00);
      wr(COUNT_OFFSET, 8'h00);
      wr(GEN_CTRL_OFFSET, 8'h01);
      wr(CTRL_OFFSET, 8'(cs));
      repeat (4 * div[cs]) @(posedge ref_clk);
      rd(COUNT_OFFSET, v);
      chk({7'b0, v >= 8'h03 && v <= 8'h07}, 8'h01);
    end
    wr(CTRL_OFFSET, 8'h00);
    rd(COUNT_OFFSET, c0);
    repeat (50) @(posedge ref_clk);
    rd(COUNT_OFFSET, v);
    chk(v, c0);
    wr(COUNT_OFFSET, 8'hFC);
    wr(IRQ_EN_OFFSET, 8'h01);
    wr(CTRL_OFFSET, 8'h01);
    repeat (12) @(posedge ref_clk);
    wr(CTRL_OFFSET, 8'h00);
    rd(IRQ_FLAG_OFFSET, v);
    chk({7'b0, v[0]}, 8'h01);
    chk({7'b0, irq_ovf}, 8'h01);
    @(posedge ref_clk);
    ovf_ack <= 1'b1;
    @(posedge ref_clk);
    ovf_ack <= 1'b0;
    rd(IRQ_FLAG_OFFSET, v);
    chk({7'b0, v[0]}, 8'h00);
    wr(IRQ_FLAG_OFFSET, 8'h03);
    rd(IRQ_FLAG_OFFSET, v);
    chk(v, 8'h00);
    wr(IRQ_EN_OFFSET, 8'h02);
    wr(COMPARE_OFFSET, 8'h05);
    wr(COUNT_OFFSET, 8'h00);
    wr(CTRL_OFFSET, 8'h19);
    repeat (40) @(posedge ref_clk);
    wr(CTRL_OFFSET, 8'h10);
    rd(COUNT_OFFSET, v);
    chk({7'b0, v <= 8'h05}, 8'h01);
    rd(IRQ_FLAG_OFFSET, v);
    chk({7'b0, v[1]}, 8'h01);
    chk({7'b0, irq_cmp}, 8'h01);
    @(posedge ref_clk);
    cmp_ack <= 1'b1;
    @(posedge ref_clk);
    cmp_ack <= 1'b0;
    rd(IRQ_FLAG_OFFSET, v);
    chk({7'b0, v[1]}, 8'h00);
    wr(IRQ_FLAG_OFFSET, 8'h03);
    wr(COUNT_OFFSET, 8'h03);
    // Forcing in clear-on-compare mode must leave the stopped counter alone.
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h38 : (i == 1) ? 8'h28 : 8'h18;
      wr(CTRL_OFFSET, v);
      wr(CTRL_OFFSET, v | 8'h80);
      repeat (3) @(posedge ref_clk);
      #1 chk({7'b0, cmp_pin}, (i == 1) ? 8'h00 : 8'h01);
    end
    rd(IRQ_FLAG_OFFSET, v);
    chk(v, 8'h00);
    rd(COUNT_OFFSET, v);
    chk(v, 8'h03);
    wr(IRQ_EN_OFFSET, 8'h00);
    wr(ASYNC_STAT_OFFSET, 8'h08);
    repeat (3) @(posedge ref_clk);
    #1 chk({6'b0, detached, xtal_en}, 8'h03);
    wait_idle();
    wr(COMPARE_OFFSET, 8'h33);
    wr(COUNT_OFFSET, 8'h10);
    rd(ASYNC_STAT_OFFSET, v);
    chk(v, 8'h0E);
    repeat (8) @(posedge ref_clk);
    rd(ASYNC_STAT_OFFSET, v);
    chk({6'b0, v[2:1]}, 8'h03);
    wait_idle();
    rd(COMPARE_OFFSET, v);
    chk(v, 8'h33);
    wr(CTRL_OFFSET, 8'h01);
    wait_idle();
    rd(COUNT_OFFSET, c0);
    repeat (60) @(posedge ref_clk);
    rd(COUNT_OFFSET, v);
    chk({7'b0, (v - c0) >= 8'h02 && (v - c0) <= 8'h04}, 8'h01);
    wr(IRQ_EN_OFFSET, 8'h01);
    wr(IRQ_FLAG_OFFSET, 8'h03);
    wr(COUNT_OFFSET, 8'hFE);
    wait_idle();
    @(posedge ref_clk);
    sleep_save <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (wake_req !== 1'b1 && n < 200);
    chk({7'b0, wake_req}, 8'h01);
    @(posedge ref_clk);
    sleep_save <= 1'b0;
    osc_halt <= 1'b1;
    repeat (40) @(posedge ref_clk);
    osc_halt <= 1'b0;
    rd(COMPARE_OFFSET, v);
    chk(v, 8'h00);
    end_sim();
  end
endmodule

/* sim/osc_model.sv */
`timescale 1ns/1ps
module osc_model #(
  parameter int HALF = 10
) (
  // Clock and enable
  input  wire logic ref_clk,
  input  wire logic run,
  // Oscillator pin
  output logic      osc
);
  int cnt;
  initial begin
    osc = 1'b0;
    cnt = 0;
  end
  // A crystal without its amplifier does not swing, so the pin rests low while disabled.
  always @(posedge ref_clk) begin
    if (!run) begin
      osc <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      osc <= ~osc;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
